// ---- hdl/acmpc_top.sv ----
// comparator control: input select, sync, edge flag, capture route, registers
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "acmpc_consts.svh"
// Notes on behaviour
// - result high when selected positive input exceeds selected negative input
// - raw comparator output synchronised, one to two cycles of latency
// - edge field 00 toggle, 10 falling, 11 rising, 01 reserved
// - flag in bit 4 set on matching synchronised event
// - flag cleared by vector acknowledge or writing one; zero no effect
// - cmp_irq_req only when flag, enable bit 3 and global enable; irq from sticky status and mask
// - bit 7 one powers comparator off, zero powers it on
// - bit 6 selects bandgap as positive input, else positive pin
// - bit 2 routes comparator output to timer capture front end
// - mux enable with ADC off selects ADC channel as negative input
// - input-off bits kill pin buffers and force readback zero
// - ADC enabled owns the multiplexer; comparator cannot borrow it
module acmpc_top (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// processor interrupt side
	input wire logic global_irq_en,
	input wire logic irq_ack,
	output logic cmp_irq_req,
	output logic irq,
	// analog core side
	input wire logic cmp_raw,
	output logic cmp_power_off,
	output logic cmp_bandgap_sel,
	output logic neg_sel_adc,
	output logic [2:0] neg_channel,
	// adc side
	input wire logic adc_on,
	input wire logic [2:0] channel_select,
	// timer capture side
	output logic capture_in,
	// pin buffers
	input wire logic pos_pin_digital,
	input wire logic neg_pin_digital,
	output logic pos_pin_input_off,
	output logic neg_pin_input_off,
	output logic pos_pin_readback,
	output logic neg_pin_readback
);
	// ***********************************
	// register state
	// ***********************************
	logic cmp_irq_enable, cmp_capture_route, cmp_mux_enable;
	logic [1:0] edge_sel;
	logic cmp_irq_flag;
	logic [1:0] imask_r, ists_r;
	logic cmp_result, prev_r;
	logic rise, fall, evt_hit;
	logic wr_ctrl, rd_ists;
	logic pos_sync, neg_sync;

	assign wr_ctrl = reg_wr && (reg_addr == `ACMPC_ADDR_CTRL);
	assign rd_ists = reg_rd && (reg_addr == `ACMPC_ADDR_ISTS);

	// control bits of the main register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmp_power_off <= 1'b0;
			cmp_bandgap_sel <= 1'b0;
			cmp_irq_enable <= 1'b0;
			cmp_capture_route <= 1'b0;
			edge_sel <= 2'b00;
		end else if (ce && wr_ctrl) begin
			cmp_power_off <= reg_wdata[`ACMPC_BIT_PWROFF];
			cmp_bandgap_sel <= reg_wdata[`ACMPC_BIT_BG];
			cmp_irq_enable <= reg_wdata[`ACMPC_BIT_IEN];
			cmp_capture_route <= reg_wdata[`ACMPC_BIT_CAP];
			edge_sel <= reg_wdata[1:0];
		end
	end

	// mux enable and pin input-off bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmp_mux_enable <= 1'b0;
			pos_pin_input_off <= 1'b0;
			neg_pin_input_off <= 1'b0;
		end else if (ce && reg_wr) begin
			if (reg_addr == `ACMPC_ADDR_MUXB) begin
				cmp_mux_enable <= reg_wdata[`ACMPC_BIT_MUXEN];
			end
			if (reg_addr == `ACMPC_ADDR_DIDR) begin
				pos_pin_input_off <= reg_wdata[`ACMPC_BIT_POSOFF];
				neg_pin_input_off <= reg_wdata[`ACMPC_BIT_NEGOFF];
			end
		end
	end

	// ***********************************
	// input selection
	// ***********************************
	// mux borrowed only while the adc is off
	assign neg_sel_adc = cmp_mux_enable && !adc_on;
	assign neg_channel = neg_sel_adc ? channel_select : 3'b000;

	// ***********************************
	// synchronisers and edge detect
	// ***********************************
	// comparator core drives cmp_raw high when pos exceeds neg
	acmpc_sync u_sync_cmp (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(cmp_raw),
		.q(cmp_result)
	);
	acmpc_sync u_sync_pos (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(pos_pin_digital),
		.q(pos_sync)
	);
	acmpc_sync u_sync_neg (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(neg_pin_digital),
		.q(neg_sync)
	);

	// previous synchronised value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_r <= 1'b0;
		end else if (ce) begin
			prev_r <= cmp_result;
		end
	end

	assign rise = ce && cmp_result && !prev_r;
	assign fall = ce && !cmp_result && prev_r;

	// event select from edge field
	function automatic logic acmpc_match(input logic [1:0] sel, input logic r, input logic f);
		case (acmpc_pkg::acmpc_edge_t'(sel))
			acmpc_pkg::ACMPC_EDGE_TOGGLE: acmpc_match = r | f;
			acmpc_pkg::ACMPC_EDGE_FALL: acmpc_match = f;
			acmpc_pkg::ACMPC_EDGE_RISE: acmpc_match = r;
			default: acmpc_match = 1'b0;
		endcase
	endfunction
	assign evt_hit = acmpc_match(edge_sel, rise, fall);

	// ***********************************
	// flag and interrupts
	// ***********************************
	// set wins over any clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmp_irq_flag <= 1'b0;
		end else if (ce) begin
			if (evt_hit) begin
				cmp_irq_flag <= 1'b1;
			end else if (irq_ack || (wr_ctrl && reg_wdata[`ACMPC_BIT_FLAG])) begin
				cmp_irq_flag <= 1'b0;
			end
		end
	end

	assign cmp_irq_req = cmp_irq_flag && cmp_irq_enable && global_irq_en;

	// sticky status: bit0 flag event, bit1 power toggle
	logic pwr_prev_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwr_prev_r <= 1'b0;
		end else if (ce) begin
			pwr_prev_r <= cmp_power_off;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ists_r <= 2'b00;
			imask_r <= 2'b00;
		end else if (ce) begin
			ists_r <= (rd_ists ? 2'b00 : ists_r) | {pwr_prev_r ^ cmp_power_off, evt_hit};
			if (reg_wr && reg_addr == `ACMPC_ADDR_IMSK) begin
				imask_r <= reg_wdata[1:0];
			end
		end
	end
	assign irq = |(ists_r & imask_r);

	// ***********************************
	// capture route and pin readback
	// ***********************************
	assign capture_in = cmp_capture_route & cmp_result;
	assign pos_pin_readback = pos_sync & !pos_pin_input_off;
	assign neg_pin_readback = neg_sync & !neg_pin_input_off;

	// ***********************************
	// read data
	// ***********************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `ACMPC_RST_BYTE;
		end else if (ce) begin
			reg_rdata <= `ACMPC_RST_BYTE;
			if (reg_rd) begin
				case (reg_addr)
					`ACMPC_ADDR_CTRL: reg_rdata <= {cmp_power_off, cmp_bandgap_sel,
						cmp_result, cmp_irq_flag, cmp_irq_enable, cmp_capture_route,
						edge_sel};
					`ACMPC_ADDR_MUXB: reg_rdata <= {1'b0, cmp_mux_enable, 6'b00_0000};
					`ACMPC_ADDR_DIDR: reg_rdata <= {6'b00_0000, neg_pin_input_off,
						pos_pin_input_off};
					`ACMPC_ADDR_IMSK: reg_rdata <= {6'b00_0000, imask_r};
					`ACMPC_ADDR_ISTS: reg_rdata <= {6'b00_0000, ists_r};
					default: reg_rdata <= `ACMPC_RST_BYTE;
				endcase
			end
		end
	end

	// ***********************************
	// assertions
	// ***********************************
	sequence rise_seq;
		!cmp_result ##1 cmp_result;
	endsequence
	edge_rise_a: assert property (@(posedge clk) disable iff (rst)
		(ce && edge_sel == 2'b11 && rise) |=> cmp_irq_flag)
		else $error("rise did not set flag");
	rsvd_edge_a: assert property (@(posedge clk) disable iff (rst)
		(edge_sel == 2'b01) |-> !evt_hit)
		else $error("reserved edge mode set flag");
	flag_set_a: assert property (@(posedge clk) disable iff (rst)
		(ce && evt_hit) |=> cmp_irq_flag)
		else $error("flag not set on event");
	flag_clr_a: assert property (@(posedge clk) disable iff (rst)
		(ce && irq_ack && !evt_hit) |=> !cmp_irq_flag)
		else $error("flag not cleared by ack");
	irq_gate_a: assert property (@(posedge clk) disable iff (rst)
		cmp_irq_req |-> (cmp_irq_flag && cmp_irq_enable && global_irq_en))
		else $error("interrupt request without all enables");
	mux_borrow_a: assert property (@(posedge clk) disable iff (rst)
		adc_on |-> !neg_sel_adc)
		else $error("mux borrowed while adc on");
	edge_pulse_a: assert property (@(posedge clk) disable iff (rst)
		(ce && rise) |=> !rise)
		else $error("rise pulse longer than one cycle");
	sync_lat_a: assert property (@(posedge clk) disable iff (rst)
		(ce && $rose(cmp_result)) |-> $past(cmp_raw, 2))
		else $error("result rose without raw input");
	readback_a: assert property (@(posedge clk) disable iff (rst)
		pos_pin_input_off |-> !pos_pin_readback)
		else $error("readback not forced to zero");
	cap_route_a: assert property (@(posedge clk) disable iff (rst)
		rise_seq |-> (capture_in == cmp_capture_route))
		else $error("capture route mismatch");

	// falling step of the synchronised output
	sequence fall_seq;
		cmp_result ##1 !cmp_result;
	endsequence
	// a falling edge in fall mode must raise the flag
	fall_flag_a: assert property (@(posedge clk) disable iff (rst)
		(ce && edge_sel == 2'b10 && fall) |=> cmp_irq_flag)
		else $error("fall did not set flag");
	// either edge in toggle mode must raise the flag
	toggle_flag_a: assert property (@(posedge clk) disable iff (rst)
		(ce && edge_sel == 2'b00 && (rise || fall)) |=> cmp_irq_flag)
		else $error("toggle did not set flag");
	// no event and a clear flag keeps the flag clear
	flag_hold_a: assert property (@(posedge clk) disable iff (rst)
		(!evt_hit && !cmp_irq_flag) |=> !cmp_irq_flag)
		else $error("flag set without event");
	// status bit follows every flag event
	ists_set_a: assert property (@(posedge clk) disable iff (rst)
		(ce && evt_hit) |=> ists_r[0])
		else $error("status not set on event");
	// frozen clock enable keeps the flag
	flag_freeze_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(cmp_irq_flag))
		else $error("flag moved while frozen");
	// writing one to the flag clears it
	clr_write_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr_ctrl && reg_wdata[`ACMPC_BIT_FLAG] && !evt_hit) |=> !cmp_irq_flag)
		else $error("flag not cleared by write one");
	// writing zero to the flag leaves it set
	zero_write_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr_ctrl && !reg_wdata[`ACMPC_BIT_FLAG] && !irq_ack && cmp_irq_flag)
		|=> cmp_irq_flag)
		else $error("flag cleared by write zero");
	// no request while the enable is off
	req_block_a: assert property (@(posedge clk) disable iff (rst)
		!cmp_irq_enable |-> !cmp_irq_req)
		else $error("request while enable off");
	// power-off bit takes the written value
	pwr_write_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr_ctrl) |=> (cmp_power_off == $past(reg_wdata[`ACMPC_BIT_PWROFF])))
		else $error("power-off write lost");
	// bandgap select takes the written value
	bg_write_a: assert property (@(posedge clk) disable iff (rst)
		(ce && wr_ctrl) |=> (cmp_bandgap_sel == $past(reg_wdata[`ACMPC_BIT_BG])))
		else $error("bandgap select write lost");
	// no capture path while the route is off
	cap_zero_a: assert property (@(posedge clk) disable iff (rst)
		!cmp_capture_route |-> !capture_in)
		else $error("capture driven while route off");
	// borrowed mux passes the channel through
	mux_sel_a: assert property (@(posedge clk) disable iff (rst)
		(cmp_mux_enable && !adc_on) |-> (neg_sel_adc && neg_channel == channel_select))
		else $error("channel not passed to negative input");
	// mux enable off keeps the negative pin
	pin_mux_a: assert property (@(posedge clk) disable iff (rst)
		!cmp_mux_enable |-> !neg_sel_adc)
		else $error("mux borrowed while disabled");
	// negative pin readback forced low
	neg_readback_a: assert property (@(posedge clk) disable iff (rst)
		neg_pin_input_off |-> !neg_pin_readback)
		else $error("negative readback not forced to zero");
	// falling pulse lasts one cycle only
	fall_pulse_a: assert property (@(posedge clk) disable iff (rst)
		fall_seq |=> !fall)
		else $error("fall pulse longer than one cycle");
	// read data idle at zero outside a read answer
	rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
		(ce && !reg_rd) |=> (reg_rdata == `ACMPC_RST_BYTE))
		else $error("read data not idle");
endmodule
`default_nettype wire

// ---- hdl/acmpc_consts.svh ----
// constants for the comparator control block
`ifndef ACMPC_CONSTS_SVH
`define ACMPC_CONSTS_SVH
`define ACMPC_ADDR_CTRL 4'h0
`define ACMPC_ADDR_MUXB 4'h1
`define ACMPC_ADDR_DIDR 4'h2
`define ACMPC_ADDR_IMSK 4'h3
`define ACMPC_ADDR_ISTS 4'h4
`define ACMPC_BIT_PWROFF 7
`define ACMPC_BIT_BG 6
`define ACMPC_BIT_RES 5
`define ACMPC_BIT_FLAG 4
`define ACMPC_BIT_IEN 3
`define ACMPC_BIT_CAP 2
`define ACMPC_BIT_MUXEN 6
`define ACMPC_BIT_POSOFF 0
`define ACMPC_BIT_NEGOFF 1
`define ACMPC_RST_BYTE 8'h00
`define ACMPC_SYNC_STAGES 2
`endif

// ---- hdl/acmpc_pkg.sv ----
// types for the comparator control block
package acmpc_pkg;
	typedef enum logic [1:0] {
		ACMPC_EDGE_TOGGLE = 2'b00,
		ACMPC_EDGE_RSVD = 2'b01,
		ACMPC_EDGE_FALL = 2'b10,
		ACMPC_EDGE_RISE = 2'b11
	} acmpc_edge_t;
endpackage

// ---- hdl/acmpc_sync.sv ----
// two-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
`default_nettype none
module acmpc_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// level in and out
	input wire logic d,
	output logic q
);
	logic meta_r;
	// first stage read only by second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ---- tb/acmpc_core_model.sv ----
// behavioural comparator core with its input selection
`timescale 1ns/100ps
`default_nettype none
module acmpc_core_model #(
	parameter logic [15:0] BG_MV = 16'h0200
) (
	// selection from the control block
	input wire logic power_off,
	input wire logic bg_sel,
	input wire logic neg_sel_adc,
	input wire logic [2:0] neg_channel,
	// pin levels in millivolts
	input wire logic [15:0] pos_mv,
	input wire logic [15:0] neg_mv,
	// raw output
	output logic cmp_raw
);
	logic [15:0] pv, nv;
	// positive side: bandgap or pin
	assign pv = bg_sel ? BG_MV : pos_mv;
	// negative side: adc channel or pin
	assign nv = neg_sel_adc ? 16'h0032 + 16'h0064 * neg_channel : neg_mv;
	// unpowered core sits low; short analog delay
	assign #3 cmp_raw = !power_off && pv > nv;
endmodule
`default_nettype wire

// ---- tb/acmpc_top_tb.sv ----
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module acmpc_top_tb;
	logic clk, rst, wr_s, rd_s, gie, ack, raw, adc_on, pwr, bgs, nsa, cap, irq, req;
	logic pp, np, ppo, npo, ppr, npr, ce;
	logic [2:0] nch, chs;
	logic [3:0] addr;
	logic [7:0] wd, rdd, v;
	logic [15:0] pos_mv;
	logic [31:0] r;
	int error_cnt, checks_done, i;
	int cyc = 0;
	logic [1:0] modes [3] = '{2'b00, 2'b10, 2'b11};
	acmpc_top DUT (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdd), .global_irq_en(gie), .irq_ack(ack),
		.cmp_irq_req(req), .irq(irq), .cmp_raw(raw), .cmp_power_off(pwr),
		.cmp_bandgap_sel(bgs), .neg_sel_adc(nsa), .neg_channel(nch), .adc_on(adc_on),
		.channel_select(chs), .capture_in(cap), .pos_pin_digital(pp), .neg_pin_digital(np),
		.pos_pin_input_off(ppo), .neg_pin_input_off(npo), .pos_pin_readback(ppr),
		.neg_pin_readback(npr));
	acmpc_core_model CORE (.power_off(pwr), .bg_sel(bgs), .neg_sel_adc(nsa),
		.neg_channel(nch), .pos_mv(pos_mv), .neg_mv(16'h0100), .cmp_raw(raw));
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// cut a hung run short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one-cycle register write
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) begin
			addr <= a;
			wd <= d;
			wr_s <= 1'b1;
		end
		@(posedge clk) wr_s <= 1'b0;
	endtask
	// read strobe, data taken in the following cycle
	task automatic rd(input logic [3:0] a);
		@(posedge clk) begin
			addr <= a;
			rd_s <= 1'b1;
		end
		@(posedge clk) rd_s <= 1'b0;
		@(negedge clk) v = rdd;
	endtask
	// move the positive pin, then let the synchroniser settle
	task automatic set_pos(input logic [15:0] mv);
		@(posedge clk) pos_mv <= mv;
		repeat (4) @(posedge clk);
	endtask
	// expected result for a random setting
	function automatic logic exp_res(input logic [31:0] x);
		logic [15:0] p, n;
		p = x[6] ? 16'h0200 : {6'h00, x[26:17]};
		n = (x[8] && !x[11]) ? 16'h0032 + 16'h0064 * x[14:12] : 16'h0100;
		return p > n;
	endfunction
	// main sequence
	initial begin
		{wr_s, rd_s, gie, ack, adc_on, pp, np} = '0;
		ce = 1'b1;
		addr = 4'h0;
		wd = 8'h00;
		chs = 3'h0;
		pos_mv = 16'h0010;
		rst = 1'b1;
		void'($urandom(29039));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 5; i++) begin
			rd(i[3:0]);
			`CHK(v, 8'h00)
		end
		wr(4'hf, 8'hff);
		rd(4'hf);
		`CHK(v, 8'h00)
		$display("reset test done");
		for (i = 0; i < 3; i++) begin
			wr(4'h0, {6'h05, modes[i]});
			set_pos(16'h0200);
			rd(4'h0);
			`CHK(v[5:4], ({1'b1, modes[i] != 2'b10}))
			wr(4'h0, {6'h05, modes[i]});
			set_pos(16'h0010);
			rd(4'h0);
			`CHK(v[5:4], ({1'b0, modes[i] != 2'b11}))
		end
		$display("edge test done");
		wr(4'h3, 8'h01);
		rd(4'h4);
		wr(4'h0, 8'h1b);
		@(posedge clk) gie <= 1'b1;
		set_pos(16'h0200);
		`CHK(({req, irq}), 2'b11)
		rd(4'h4);
		`CHK(({irq, v}), 9'h001)
		@(posedge clk) gie <= 1'b0;
		@(negedge clk) `CHK(req, 1'b0)
		wr(4'h0, 8'h0b);
		rd(4'h0);
		`CHK(v[4], 1'b1)
		wr(4'h0, 8'h1b);
		rd(4'h0);
		`CHK(v[4], 1'b0)
		set_pos(16'h0010);
		set_pos(16'h0200);
		@(posedge clk) ack <= 1'b1;
		@(posedge clk) ack <= 1'b0;
		rd(4'h0);
		`CHK(v[5:3], 3'b101)
		wr(4'h0, 8'h03);
		$display("irq test done");
		for (i = 0; i < 12; i++) begin
			r = $urandom;
			wr(4'h0, r[7:0] & 8'hc4);
			wr(4'h1, {1'b0, r[8], 6'h00});
			wr(4'h2, {6'h00, r[10:9]});
			@(posedge clk) begin
				adc_on <= r[11];
				chs <= r[14:12];
				pp <= r[15];
				np <= r[16];
			end
			set_pos({6'h00, r[26:17]});
			rd(4'h0);
			`CHK(v & 8'hc4, r[7:0] & 8'hc4)
			`CHK(({pwr, bgs}), r[7:6])
			`CHK(({nsa, nch}), (r[8] && !r[11] ? {1'b1, r[14:12]} : 4'h0))
			`CHK(({ppo, npo, ppr, npr}), ({r[9], r[10], r[15] & !r[9], r[16] & !r[10]}))
			if (!r[7])
				`CHK(({v[5], cap}), ({exp_res(r), r[2] & exp_res(r)}))
		end
		$display("random test done");
		wr(4'h0, 8'h00);
		@(posedge clk) ce <= 1'b0;
		wr(4'h0, 8'h80);
		@(posedge clk) ce <= 1'b1;
		rd(4'h0);
		`CHK(v[7], 1'b0)
		$display("freeze test done");
		final_report();
	end
endmodule
`default_nettype wire
